// ---- pkg/sfm_defines.svh ----
// constants for the solenoid fault monitor: widths, pin positions, filter timing
// assumes inclusion by bare name from the package and from each design file
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// ==========================================
// sizes
`define SFM_NCH 2
`define SFM_SPW 11
`define SFM_NPIN 23
`define SFM_CNTW 6

// ==========================================
// positions in the synchronised pin vector (per-channel groups are 2 bits)
`define SFM_P_ILO 0
`define SFM_P_IHI 2
`define SFM_P_OCLS 4
`define SFM_P_OL 6
`define SFM_P_SBAT 8
`define SFM_P_SGND 10
`define SFM_P_OT 12
`define SFM_P_UV 14
`define SFM_P_OV 16
`define SFM_P_XRST 17
`define SFM_P_ENP 18
`define SFM_P_VUV 19
`define SFM_P_CLKF 20
`define SFM_P_WD 21
`define SFM_P_RDY 22

// ==========================================
// overcurrent filter interval, in system-clock cycles
`define SFM_OVERCURRENT_FILTER_MIN_CYC 20
`define SFM_OVERCURRENT_FILTER_MAX_CYC 40
`define SFM_OVERCURRENT_FILTER_CYC ((`SFM_OVERCURRENT_FILTER_MIN_CYC + `SFM_OVERCURRENT_FILTER_MAX_CYC) / 2)

`endif

// ---- pkg/sfm_pkg.sv ----
// types of the solenoid fault monitor: registered state of each module
// assumes sfm_defines.svh is on the include path
`include "sfm_defines.svh"

package sfm_pkg;

	// ==========================================
	// top module state
	typedef struct packed {
		logic [`SFM_NPIN-1:0]                sync1;
		logic [`SFM_NPIN-1:0]                sync2;
		logic [`SFM_NCH-1:0]                 en;
		logic [`SFM_NCH-1:0][`SFM_SPW-1:0]   sp;
		logic [`SFM_NCH-1:0]                 overcurrent_flag;
		logic [`SFM_NCH-1:0]                 ot;
		logic [`SFM_NCH-1:0]                 uv;
		logic [`SFM_NCH-1:0]                 olb;
		logic [`SFM_NCH-1:0]                 offf;
		logic                                ov;
		logic                                wd;
		logic                                alert_oe_n;
		logic                                alert_lvl;
	} sfm_state_s;

	// ==========================================
	// overcurrent filter state
	typedef struct packed {
		logic [`SFM_CNTW-1:0] cnt;
		logic                 prev_on;
		logic                 trip;
	} sfm_filt_s;

endpackage

// ---- rtl/sfm_oc_filter.sv ----
// overcurrent filter and quick-shutoff decision for one channel
// assumes all inputs are already synchronous to clk_i
`timescale 1ns/1ns
`include "sfm_defines.svh"

module sfm_oc_filter
	import sfm_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic arm_i,
	input  wire logic over_low_i,
	input  wire logic over_high_i,
	input  wire logic stage_on_i,
	output logic      trip_o
);

	localparam logic [`SFM_CNTW-1:0] LastCnt = `SFM_CNTW'(`SFM_OVERCURRENT_FILTER_CYC - 1);

	sfm_filt_s q, d;
	logic      chg;

	assign chg = stage_on_i != q.prev_on;

	always_comb begin
		d = q;
		if (ce_i) begin
			d.prev_on = stage_on_i;
			// a stage that switches before the interval ends raises nothing
			if (!arm_i || !over_low_i || chg) begin
				d.cnt = '0;
			end else if (q.cnt != LastCnt) begin
				d.cnt = q.cnt + `SFM_CNTW'(1);
			end
			// high limit bypasses the filter entirely
			d.trip = arm_i && (over_high_i ||
				(over_low_i && !chg && q.cnt == LastCnt));
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign trip_o = q.trip;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	quick_trip_a: assert property (ce_i && arm_i && over_high_i |=> trip_o)
		else $error("high limit did not trip at once");
	arm_gate_a: assert property (ce_i && !arm_i |=> !trip_o)
		else $error("trip while channel not armed");
	filter_time_a: assert property (
		trip_o && !$past(over_high_i) |-> $past(q.cnt) == LastCnt)
		else $error("low limit tripped before filter interval");

endmodule

// ---- rtl/sfm_fault_monitor.sv ----
// solenoid fault monitor: channel shutdown on faults, latched flags, alert line
// assumes analog comparator and status pins are asynchronous; controls are on clk_i
`timescale 1ns/1ns
`include "sfm_defines.svh"

module sfm_fault_monitor
	import sfm_pkg::*;
(
	input  wire logic                              clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic                              ce_i,
	input  wire logic [`SFM_NCH-1:0]               ilim_low_i,
	input  wire logic [`SFM_NCH-1:0]               ilim_high_i,
	input  wire logic [`SFM_NCH-1:0]               oc_at_ls_fet_i,
	input  wire logic [`SFM_NCH-1:0]               open_load_i,
	input  wire logic [`SFM_NCH-1:0]               short_bat_i,
	input  wire logic [`SFM_NCH-1:0]               short_gnd_i,
	input  wire logic [`SFM_NCH-1:0]               overtemp_i,
	input  wire logic [`SFM_NCH-1:0]               load_supply_uv_i,
	input  wire logic                              bat_overvoltage_i,
	input  wire logic                              external_reset_n_i,
	input  wire logic                              enable_pin_i,
	input  wire logic                              logic_supply_uv_i,
	input  wire logic                              clock_fault_i,
	input  wire logic                              watchdog_event_i,
	input  wire logic                              power_ready_i,
	input  wire logic [`SFM_NCH-1:0]               high_side_i,
	input  wire logic [`SFM_NCH-1:0]               channel_alert_mask_i,
	input  wire logic                              enable_pin_alert_mask_i,
	input  wire logic [`SFM_NCH-1:0]               stage_on_i,
	input  wire logic [`SFM_NCH-1:0]               enable_wr_i,
	input  wire logic [`SFM_NCH-1:0]               enable_wdata_i,
	input  wire logic [`SFM_NCH-1:0]               setpoint_wr_i,
	input  wire logic [`SFM_NCH-1:0][`SFM_SPW-1:0] setpoint_wdata_i,
	input  wire logic                              diag_rd_i,
	output logic [`SFM_NCH-1:0]                    channel_enable_o,
	output logic [`SFM_NCH-1:0][`SFM_SPW-1:0]      setpoint_o,
	output logic [`SFM_NCH-1:0]                    channel_overcurrent_flag_o,
	output logic [`SFM_NCH-1:0]                    channel_overtemp_flag_o,
	output logic [`SFM_NCH-1:0]                    channel_undervoltage_flag_o,
	output logic [`SFM_NCH-1:0]                    open_load_bypass_flag_o,
	output logic [`SFM_NCH-1:0]                    offstate_fault_o,
	output logic                                   bat_overvoltage_flag_o,
	output logic                                   watchdog_flag_o,
	output logic                                   fault_alert_n_o,
	output logic                                   fault_alert_oe_n_o
);

	// ==========================================
	// helpers
	function automatic logic active(input logic en, input logic [`SFM_SPW-1:0] sp);
		active = en && (sp != '0);
	endfunction

	sfm_state_s               q, d;
	logic [`SFM_NPIN-1:0]     pins;
	logic [`SFM_NCH-1:0]      arm, trip, oc_match, oc_mis, on_byp, bypass_cond;
	logic [`SFM_NCH-1:0]      s_ilo, s_ihi, s_ocls, s_ol, s_sbat, s_sgnd, s_ot, s_uv;
	logic                     s_ov, s_xrst_n, s_enp, s_vuv, s_clkf, s_wd, s_rdy;
	logic                     glob_src;

	assign pins = {power_ready_i, watchdog_event_i, clock_fault_i, logic_supply_uv_i,
		enable_pin_i, external_reset_n_i, bat_overvoltage_i, load_supply_uv_i,
		overtemp_i, short_gnd_i, short_bat_i, open_load_i, oc_at_ls_fet_i,
		ilim_high_i, ilim_low_i};

	assign s_ilo    = q.sync2[`SFM_P_ILO +: 2];
	assign s_ihi    = q.sync2[`SFM_P_IHI +: 2];
	assign s_ocls   = q.sync2[`SFM_P_OCLS +: 2];
	assign s_ol     = q.sync2[`SFM_P_OL +: 2];
	assign s_sbat   = q.sync2[`SFM_P_SBAT +: 2];
	assign s_sgnd   = q.sync2[`SFM_P_SGND +: 2];
	assign s_ot     = q.sync2[`SFM_P_OT +: 2];
	assign s_uv     = q.sync2[`SFM_P_UV +: 2];
	assign s_ov     = q.sync2[`SFM_P_OV];
	assign s_xrst_n = q.sync2[`SFM_P_XRST];
	assign s_enp    = q.sync2[`SFM_P_ENP];
	assign s_vuv    = q.sync2[`SFM_P_VUV];
	assign s_clkf   = q.sync2[`SFM_P_CLKF];
	assign s_wd     = q.sync2[`SFM_P_WD];
	assign s_rdy    = q.sync2[`SFM_P_RDY];

	// ==========================================
	// per-channel overcurrent filters and fault classification
	for (genvar c = 0; c < `SFM_NCH; c++) begin : g_ch
		assign arm[c] = active(q.en[c], q.sp[c]);
		sfm_oc_filter u_filt (
			.clk_i       (clk_i),
			.rst_n_i     (rst_n_i),
			.ce_i        (ce_i),
			.arm_i       (arm[c]),
			.over_low_i  (s_ilo[c]),
			.over_high_i (s_ihi[c]),
			.stage_on_i  (stage_on_i[c]),
			.trip_o      (trip[c])
		);
		// transistor matching the configured side counts as overcurrent
		assign oc_match[c] = trip[c] && (high_side_i[c] ? !s_ocls[c] : s_ocls[c]);
		assign oc_mis[c]   = trip[c] && !oc_match[c];
		// a high side short to ground shows up as overcurrent, not here
		assign bypass_cond[c] = s_ol[c] || (high_side_i[c] ? s_sbat[c] : s_sgnd[c]);
		assign on_byp[c] = arm[c] && bypass_cond[c];
	end

	// sources that no mask can silence, plus the low enable pin when enable_pin_alert_mask_i is set
	assign glob_src = !s_xrst_n || s_vuv || s_clkf || q.ov || q.wd || !s_rdy
		|| (enable_pin_alert_mask_i && !s_enp);

	// ==========================================
	// next state
	always_comb begin
		logic alert;
		logic kill;
		logic pend;
		alert = 1'b0;
		kill  = 1'b0;
		pend  = 1'b0;
		d = q;
		if (ce_i) begin
			d.sync1 = pins;
			d.sync2 = q.sync1;
			for (int c = 0; c < `SFM_NCH; c++) begin
				// set after clear so a fault in the read cycle survives
				if (diag_rd_i) begin
					d.overcurrent_flag[c] = 1'b0;
					if (!s_ot[c]) d.ot[c] = 1'b0;
					if (!s_uv[c]) d.uv[c] = 1'b0;
					if (!bypass_cond[c]) d.olb[c] = 1'b0;
				end
				if (oc_match[c]) d.overcurrent_flag[c] = 1'b1;
				if (oc_mis[c] || on_byp[c]) d.olb[c] = 1'b1;
				if (s_ot[c]) d.ot[c] = 1'b1;
				if (s_uv[c]) d.uv[c] = 1'b1;
				d.offf[c] = !arm[c] && bypass_cond[c];

				// enable cannot be rewritten until the report has been read
				pend = q.overcurrent_flag[c] || q.ot[c] || q.uv[c] || q.olb[c] || q.ov;
				if (enable_wr_i[c] && !pend) d.en[c] = enable_wdata_i[c];
				if (setpoint_wr_i[c]) d.sp[c] = setpoint_wdata_i[c];
				kill = trip[c] || on_byp[c] || s_ot[c] || s_uv[c] || s_ov;
				if (kill) begin
					d.en[c] = 1'b0;
					d.sp[c] = '0;
				end

				alert = alert || (channel_alert_mask_i[c]
					&& (q.ot[c] || q.overcurrent_flag[c] || q.uv[c] || q.olb[c]));
			end
			if (diag_rd_i && !s_ov) d.ov = 1'b0;
			if (s_ov) d.ov = 1'b1;
			if (diag_rd_i) d.wd = 1'b0;
			if (s_wd) d.wd = 1'b1;
			d.alert_oe_n = !(alert || glob_src);
			d.alert_lvl  = 1'b0;
		end
	end

	// reset pulls the alert low: the power-up hold starts here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign channel_enable_o            = q.en;
	assign setpoint_o                  = q.sp;
	assign channel_overcurrent_flag_o  = q.overcurrent_flag;
	assign channel_overtemp_flag_o     = q.ot;
	assign channel_undervoltage_flag_o = q.uv;
	assign open_load_bypass_flag_o     = q.olb;
	assign offstate_fault_o            = q.offf;
	assign bat_overvoltage_flag_o      = q.ov;
	assign watchdog_flag_o             = q.wd;
	assign fault_alert_n_o             = q.alert_lvl;
	assign fault_alert_oe_n_o          = q.alert_oe_n;

	// ==========================================
	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence oc_trip0_s;
		ce_i && oc_match[0];
	endsequence
	sequence ch0_off_s;
		!q.en[0] && q.sp[0] == '0;
	endsequence

	power_up_hold_a: assert property (ce_i && !s_rdy |=> !fault_alert_oe_n_o)
		else $error("alert released before ready");
	open_drain_a: assert property (fault_alert_n_o == 1'b0)
		else $error("alert line driven high");
	enpin_mask_a: assert property (ce_i && enable_pin_alert_mask_i && !s_enp
		|=> !fault_alert_oe_n_o)
		else $error("low enable pin did not pull the alert");
	chan_mask_a: assert property (ce_i && !glob_src && channel_alert_mask_i == '0
		|=> fault_alert_oe_n_o)
		else $error("masked source pulled the alert");
	chan_alert_a: assert property (ce_i && channel_alert_mask_i[0] && q.overcurrent_flag[0]
		|=> !fault_alert_oe_n_o)
		else $error("unmasked channel flag did not pull the alert");
	oc_shutdown_a: assert property (oc_trip0_s |=> ch0_off_s ##0 q.overcurrent_flag[0])
		else $error("overcurrent did not shut channel down");
	ovc_hold_a: assert property (ce_i && q.overcurrent_flag[0] && !diag_rd_i |=> q.overcurrent_flag[0])
		else $error("overcurrent flag lost without a read");
	ovc_clear_a: assert property (ce_i && diag_rd_i && !oc_match[0] |=> !q.overcurrent_flag[0])
		else $error("overcurrent flag survived a read");
	relock_a: assert property (ce_i && q.overcurrent_flag[0] && enable_wr_i[0] |=> !q.en[0])
		else $error("enable rewritten before report read");
	ov_all_off_a: assert property (ce_i && s_ov |=> q.en == '0 && q.ov)
		else $error("overvoltage left a channel enabled");
	ot_shutdown_a: assert property (ce_i && s_ot[1] |=> !q.en[1] && q.ot[1])
		else $error("overtemperature did not shut channel");
	mismatch_a: assert property (ce_i && oc_mis[0] |=> ch0_off_s ##0 q.olb[0])
		else $error("opposite transistor fault misfiled");

endmodule

// ---- dv/sfm_host_model.sv ----
// host model: reads the fault report unless skip_read_i is set, then re-arms both channels
// assumes service_i is raised for one cycle between rising edges
`timescale 1ns/1ns
`include "sfm_defines.svh"

module sfm_host_model (
	input  wire logic                              clk_i,
	input  wire logic                              service_i,
	input  wire logic                              skip_read_i,
	input  wire logic [`SFM_SPW-1:0]               sp_i,
	output logic                                   diag_rd_o,
	output logic [`SFM_NCH-1:0]                    enable_wr_o,
	output logic [`SFM_NCH-1:0]                    enable_wdata_o,
	output logic [`SFM_NCH-1:0]                    setpoint_wr_o,
	output logic [`SFM_NCH-1:0][`SFM_SPW-1:0]      setpoint_wdata_o
);
	// ==========================================
	// service sequence
	// released data lines carry the inverse so a stale value never looks fresh
	initial begin
		diag_rd_o = 1'b0;
		enable_wr_o = 2'h0;
		enable_wdata_o = 2'h0;
		setpoint_wr_o = 2'h0;
		setpoint_wdata_o = '1;
	end
	always @(posedge clk_i) begin
		if (service_i) begin
			@(negedge clk_i) diag_rd_o = !skip_read_i;
			@(negedge clk_i) diag_rd_o = 1'b0;
			enable_wr_o = 2'h3;
			enable_wdata_o = 2'h3;
			@(negedge clk_i) enable_wr_o = 2'h0;
			enable_wdata_o = 2'h0;
			setpoint_wr_o = 2'h3;
			setpoint_wdata_o = {sp_i, sp_i};
			@(negedge clk_i) setpoint_wr_o = 2'h0;
			setpoint_wdata_o = ~{sp_i, sp_i};
		end
	end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the solenoid fault monitor, with a reference model in ints
// assumes the host model drives every register write and report read
`timescale 1ns/1ns
`include "sfm_defines.svh"

module testbench;
	logic              clk, rst_n, pwr_rdy, en_pin, en_mask, bat_ov, service, ce, skip;
	logic [1:0]        ilo, ihi, ls_fet, opn, sbat, sgnd, ot_pin, uv_pin, hs, cmask, stage;
	logic [3:0]        src;
	logic [10:0]       sp_val;
	logic              diag_rd, ov_o, wd_o, al_n, al_oe_n;
	logic [1:0]        en_wr, en_wd, sp_wr, en_o, ovc_o, ot_o, uv_o, olb_o, off_o;
	logic [1:0][10:0]  sp_wd, sp_o;
	int                n_errors, checks, m_ov, m_wd;
	int                m_en[2], m_sp[2], m_ovc[2], m_olb[2], m_ot[2], m_uv[2];

	sfm_fault_monitor sfm_fault_monitor_inst (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
		.ilim_low_i(ilo), .ilim_high_i(ihi), .oc_at_ls_fet_i(ls_fet), .open_load_i(opn),
		.short_bat_i(sbat), .short_gnd_i(sgnd), .overtemp_i(ot_pin), .load_supply_uv_i(uv_pin),
		.bat_overvoltage_i(bat_ov), .external_reset_n_i(!src[0]), .enable_pin_i(en_pin),
		.logic_supply_uv_i(src[1]), .clock_fault_i(src[2]), .watchdog_event_i(src[3]),
		.power_ready_i(pwr_rdy), .high_side_i(hs), .channel_alert_mask_i(cmask),
		.enable_pin_alert_mask_i(en_mask), .stage_on_i(stage), .enable_wr_i(en_wr),
		.enable_wdata_i(en_wd), .setpoint_wr_i(sp_wr), .setpoint_wdata_i(sp_wd),
		.diag_rd_i(diag_rd), .channel_enable_o(en_o), .setpoint_o(sp_o),
		.channel_overcurrent_flag_o(ovc_o), .channel_overtemp_flag_o(ot_o),
		.channel_undervoltage_flag_o(uv_o), .open_load_bypass_flag_o(olb_o),
		.offstate_fault_o(off_o), .bat_overvoltage_flag_o(ov_o), .watchdog_flag_o(wd_o),
		.fault_alert_n_o(al_n), .fault_alert_oe_n_o(al_oe_n));

	sfm_host_model sfm_host_model_inst (.clk_i(clk), .service_i(service), .sp_i(sp_val),
		.skip_read_i(skip), .diag_rd_o(diag_rd), .enable_wr_o(en_wr), .enable_wdata_o(en_wd),
		.setpoint_wr_o(sp_wr), .setpoint_wdata_o(sp_wd));

	// ==========================================
	// helpers
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	function int rnd();
		return $urandom_range(2047, 1);
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task check_all();
		logic low;
		low = !pwr_rdy || m_ov != 0 || m_wd != 0 || src[2:0] != 0 || (en_mask && !en_pin);
		for (int c = 0; c < 2; c++) begin
			low = low || (cmask[c] && (m_ovc[c] || m_ot[c] || m_uv[c] || m_olb[c]));
			chk(en_o[c], m_en[c], "enable");
			chk(sp_o[c], m_sp[c], "setpoint");
			chk(ovc_o[c], m_ovc[c], "overcurrent flag");
			chk(olb_o[c], m_olb[c], "bypass flag");
			chk(ot_o[c], m_ot[c], "overtemp flag");
			chk(uv_o[c], m_uv[c], "undervoltage flag");
		end
		chk(ov_o, m_ov, "overvoltage flag");
		chk(wd_o, m_wd, "watchdog flag");
		chk(al_oe_n, !low, "alert enable");
		chk(al_n, 0, "alert data");
	endtask

	// host service plus the model's view of what a read and re-arm do
	task svc(input int v);
		sp_val = v[10:0];
		service = 1'b1;
		cyc(1);
		service = 1'b0;
		cyc(5);
		if (!skip) begin
			m_wd = 0;
			if (!bat_ov) m_ov = 0;
		end
		for (int c = 0; c < 2; c++) begin
			if (!skip) begin
				m_ovc[c] = 0;
				m_olb[c] = 0;
				if (!ot_pin[c]) m_ot[c] = 0;
				if (!uv_pin[c]) m_uv[c] = 0;
			end
			// without a report read a pending flag refuses the enable write
			if (!(m_ot[c] || m_uv[c] || m_ov || m_ovc[c] || m_olb[c])) m_en[c] = 1;
			m_sp[c] = (ot_pin[c] || uv_pin[c] || bat_ov) ? 0 : v;
		end
	endtask

	// quick trip is seen on the 4th edge, the alert one edge later;
	// the slow one must not trip before 20 cycles
	task trip(input int c, input int quick, input int opp);
		ls_fet[c] = hs[c] ^ !opp;
		if (quick) ihi[c] = 1'b1;
		else ilo[c] = 1'b1;
		if (quick) cyc(5);
		else begin
			cyc(20);
			check_all();
			cyc(24);
		end
		ihi[c] = 1'b0;
		ilo[c] = 1'b0;
		m_en[c] = 0;
		m_sp[c] = 0;
		if (opp) m_olb[c] = 1;
		else m_ovc[c] = 1;
	endtask

	task results();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// clock, watchdog, scenarios
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#(100 * 3000);
		n_errors++;
		$display("ERROR %0t watchdog expired", $time);
		results();
	end

	initial begin
		{rst_n, pwr_rdy, bat_ov, service, ilo, ihi, ls_fet, opn, sbat, sgnd} = '0;
		{ot_pin, uv_pin, stage, src, en_mask, sp_val} = '0;
		en_pin = 1'b1;
		ce = 1'b1;
		skip = 1'b0;
		hs = 2'h1;
		cmask = 2'h3;
		void'($urandom(54));
		cyc(20);
		chk(al_oe_n, 0, "alert in reset");
		rst_n = 1'b1;
		cyc(10);
		check_all();
		pwr_rdy = 1'b1;
		cyc(3);
		check_all();
		svc(rnd());
		check_all();
		trip(0, 1, 0);
		check_all();
		cmask = 2'h0;
		cyc(2);
		check_all();
		cmask = 2'h3;
		skip = 1'b1;
		svc(rnd());
		check_all();
		skip = 1'b0;
		svc(rnd());
		check_all();
		cmask = 2'h1;
		trip(1, 1, 0);
		check_all();
		cmask = 2'h3;
		svc(0);
		ihi = 2'h3;
		cyc(6);
		ihi = 2'h0;
		check_all();
		for (int h = 0; h < 2; h++) begin
			hs[0] = h[0];
			for (int k = 0; k < 3; k++) begin
				{sgnd[0], sbat[0], opn[0]} = 3'h1 << k;
				cyc(3);
				chk(off_o[0], k == 0 || (k == 1) == h, "offstate");
			end
			{sgnd[0], sbat[0], opn[0]} = 3'h0;
		end
		svc(rnd());
		for (int h = 0; h < 2; h++) begin
			hs = {h[0], h[0]};
			trip(h, 0, 0);
			check_all();
			trip(1 - h, 1, 1);
			check_all();
			svc(rnd());
			check_all();
		end
		ilo[1] = 1'b1;
		repeat (4) begin
			cyc(15);
			stage[1] = ~stage[1];
		end
		ilo[1] = 1'b0;
		cyc(3);
		check_all();
		for (int k = 0; k < 3; k++) begin
			if (k == 2) bat_ov = 1'b1;
			else if (k == 1) uv_pin[1] = 1'b1;
			else ot_pin[1] = 1'b1;
			cyc(4);
			for (int c = 0; c < 2; c++) if (k == 2 || c == 1) {m_en[c], m_sp[c]} = '0;
			if (k == 2) m_ov = 1;
			else if (k == 1) m_uv[1] = 1;
			else m_ot[1] = 1;
			check_all();
			svc(rnd());
			check_all();
			{bat_ov, uv_pin, ot_pin} = '0;
			cyc(3);
			svc(rnd());
			check_all();
		end
		for (int k = 0; k < 4; k++) begin
			src[k] = 1'b1;
			cyc(4);
			m_wd = (k == 3);
			check_all();
			src[k] = 1'b0;
			cyc(3);
			check_all();
			svc(rnd());
			check_all();
		end
		// a low clock enable must freeze the synchronisers and the alert
		ce = 1'b0;
		src[2] = 1'b1;
		cyc(5);
		chk(al_oe_n, 1, "frozen alert");
		ce = 1'b1;
		cyc(3);
		check_all();
		src[2] = 1'b0;
		cyc(3);
		check_all();
		for (int k = 0; k < 2; k++) begin
			en_mask = k[0];
			en_pin = 1'b0;
			cyc(3);
			check_all();
			en_pin = 1'b1;
			cyc(3);
			check_all();
		end
		results();
	end
endmodule
